// *** hdl/qin_msg_sender.sv ***
`timescale 1ns/10ps
// single-entry message slot: holds one vector until the sink accepts it
module qin_msg_sender (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [qin_pkg::VEC_W-1:0] load_vector,
   output logic busy,
   output logic msg_valid,
   output logic [qin_pkg::VEC_W-1:0] msg_vector,
   input wire logic msg_ready
);
   typedef struct packed {
      logic valid;
      logic [qin_pkg::VEC_W-1:0] vector;
   } qin_msg_state_t;

   qin_msg_state_t state;
   qin_msg_state_t next_state;

   always_comb begin
      next_state = state;
      if (state.valid && msg_ready) begin
         next_state.valid = 1'b0;
      end
      if (load && !next_state.valid) begin
         next_state.valid = 1'b1;
         next_state.vector = load_vector;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign busy = state.valid;
   assign msg_valid = state.valid;
   assign msg_vector = state.vector;

   property p_msg_hold;
      @(posedge clock) disable iff (!rst_n)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_vector);
   endproperty
   a_msg_hold: assert property (p_msg_hold) else $error("message dropped");
endmodule

// *** hdl/qin_notify.sv ***
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// Notes on behaviour
// - legacy queue memory is page aligned and page sized, 4096 bytes
// - ring base equals page frame number times 4096
// - reported queue size is the size in use; no negotiation
// - doorbell write of a queue index flags that queue as having work
// - queue event without message interrupts sets cause bit 0, raises line
// - queue event with message interrupts sends message on queue vector
// - unmapped queue vector suppresses queue interrupts under messages
// - config change without message interrupts sets cause bit 1, raises line
// - config change with message interrupts sends message on config vector
// - unmapped config vector suppresses config interrupts under messages
// - one interrupt may carry both queue and config causes
// - reading cause flags returns them and clears them
// - unmapped vector code is FFFF
// - cause flags unused while message interrupts are enabled
// - reset leaves every vector unmapped
module qin_notify (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [qin_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [qin_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [qin_pkg::DATA_W-1:0] reg_rdata,
   input wire logic used_event,
   input wire logic [qin_pkg::QIDX_W-1:0] used_queue,
   input wire logic config_event,
   output logic [qin_pkg::NUM_QUEUES-1:0] queue_work,
   input wire logic [qin_pkg::NUM_QUEUES-1:0] queue_work_clear,
   output logic [qin_pkg::RING_ADDR_W-1:0] ring_base,
   output logic pci_irq,
   output logic msg_valid,
   output logic [qin_pkg::VEC_W-1:0] msg_vector,
   input wire logic msg_ready,
   output logic irq
);
   typedef struct packed {
      logic [qin_pkg::QIDX_W-1:0] queue_select;
      logic [qin_pkg::NUM_QUEUES-1:0][qin_pkg::PFN_W-1:0] page_frame;
      logic [qin_pkg::NUM_QUEUES-1:0][qin_pkg::VEC_W-1:0] queue_vector;
      logic [qin_pkg::VEC_W-1:0] config_vector;
      logic [qin_pkg::NUM_QUEUES-1:0] work;
      logic [qin_pkg::NUM_QUEUES-1:0] queue_pending;
      logic config_pending;
      logic [1:0] cause;
      logic msix_enable;
      logic [qin_pkg::NUM_EVENTS-1:0] irq_status;
      logic [qin_pkg::NUM_EVENTS-1:0] irq_mask;
      logic [qin_pkg::DATA_W-1:0] rdata;
   } qin_state_t;

   qin_state_t state;
   qin_state_t next_state;

   logic busy;
   logic load;
   logic [qin_pkg::VEC_W-1:0] load_vector;
   logic [qin_pkg::VEC_W-1:0] used_vec;
   logic used_mapped;
   logic cfg_mapped;
   logic [qin_pkg::NUM_EVENTS-1:0] ev;
   logic [qin_pkg::NUM_QUEUES-1:0] q_mapped;
   logic [qin_pkg::NUM_QUEUES-1:0] q_ready;
   logic [qin_pkg::NUM_QUEUES-1:0] q_taken;
   logic [qin_pkg::QIDX_W-1:0] q_pick;
   logic cfg_taken;

   function automatic logic is_mapped(input logic [qin_pkg::VEC_W-1:0] v);
      return v != qin_pkg::UNMAPPED_VECTOR_CODE;
   endfunction

   function automatic logic hit(input logic [qin_pkg::ADDR_W-1:0] a,
                                input logic [qin_pkg::ADDR_W-1:0] off);
      return a == off;
   endfunction

   // lowest waiting queue goes first
   function automatic logic [qin_pkg::QIDX_W-1:0] first_set(
         input logic [qin_pkg::NUM_QUEUES-1:0] m);
      logic [qin_pkg::QIDX_W-1:0] idx;
      idx = '0;
      for (int i = qin_pkg::NUM_QUEUES - 1; i >= 0; i--) begin
         if (m[i]) begin
            idx = i[qin_pkg::QIDX_W-1:0];
         end
      end
      return idx;
   endfunction

   assign used_vec = state.queue_vector[used_queue];
   assign used_mapped = is_mapped(used_vec);
   assign cfg_mapped = is_mapped(state.config_vector);
   assign q_pick = first_set(q_ready);

   for (genvar i = 0; i < qin_pkg::NUM_QUEUES; i++) begin : g_queue
      assign q_mapped[i] = is_mapped(state.queue_vector[i]);
      assign q_ready[i] = state.queue_pending[i] && q_mapped[i];
   end

   // new queue event first, then config, then queues left waiting
   always_comb begin
      load = 1'b0;
      load_vector = state.config_vector;
      q_taken = '0;
      cfg_taken = 1'b0;
      if (state.msix_enable && !busy) begin
         if (used_event && used_mapped) begin
            load = 1'b1;
            load_vector = used_vec;
            q_taken[used_queue] = 1'b1;
         end else if ((config_event || state.config_pending) && cfg_mapped) begin
            load = 1'b1;
            load_vector = state.config_vector;
            cfg_taken = 1'b1;
         end else if (|q_ready) begin
            load = 1'b1;
            load_vector = state.queue_vector[q_pick];
            q_taken[q_pick] = 1'b1;
         end
      end
   end

   qin_msg_sender u_sender (
      .clock(clock),
      .rst_n(rst_n),
      .load(load),
      .load_vector(load_vector),
      .busy(busy),
      .msg_valid(msg_valid),
      .msg_vector(msg_vector),
      .msg_ready(msg_ready)
   );

   always_comb begin
      ev = '0;
      ev[qin_pkg::EV_DOORBELL] = reg_write &&
         hit(reg_addr, qin_pkg::OFF_DOORBELL_INDEX);
      ev[qin_pkg::EV_MSG_SENT] = msg_valid && msg_ready;
      ev[qin_pkg::EV_SUPPRESSED] = state.msix_enable &&
         ((used_event && !used_mapped) || (config_event && !cfg_mapped));
   end

   always_comb begin
      next_state = state;
      next_state.rdata = '0;
      next_state.work = state.work & ~queue_work_clear;
      if (reg_read) begin
         unique case (reg_addr)
            qin_pkg::OFF_QUEUE_SELECT:
               next_state.rdata = {{(qin_pkg::DATA_W-qin_pkg::QIDX_W){1'b0}},
                                   state.queue_select};
            qin_pkg::OFF_RING_PAGE_FRAME:
               next_state.rdata = state.page_frame[state.queue_select];
            qin_pkg::OFF_QUEUE_SIZE:
               next_state.rdata = {16'h0000, qin_pkg::QUEUE_SIZE_DEFAULT};
            qin_pkg::OFF_CAUSE_FLAGS: begin
               next_state.rdata = {30'h0, state.cause};
               next_state.cause = qin_pkg::CAUSE_RESET;
            end
            qin_pkg::OFF_CONFIG_VECTOR:
               next_state.rdata = {16'h0000, state.config_vector};
            qin_pkg::OFF_QUEUE_VECTOR:
               next_state.rdata = {16'h0000,
                                   state.queue_vector[state.queue_select]};
            qin_pkg::OFF_CONTROL:
               next_state.rdata = {31'h0, state.msix_enable};
            qin_pkg::OFF_IRQ_STATUS:
               next_state.rdata = {29'h0, state.irq_status};
            qin_pkg::OFF_IRQ_MASK:
               next_state.rdata = {29'h0, state.irq_mask};
            default:
               next_state.rdata = '0;
         endcase
      end
      if (reg_write) begin
         unique case (reg_addr)
            qin_pkg::OFF_QUEUE_SELECT:
               next_state.queue_select = reg_wdata[qin_pkg::QIDX_W-1:0];
            qin_pkg::OFF_RING_PAGE_FRAME:
               next_state.page_frame[state.queue_select] = reg_wdata;
            qin_pkg::OFF_DOORBELL_INDEX:
               if (reg_wdata[15:0] < 16'(qin_pkg::NUM_QUEUES)) begin
                  next_state.work[reg_wdata[qin_pkg::QIDX_W-1:0]] = 1'b1;
               end
            qin_pkg::OFF_CONFIG_VECTOR:
               next_state.config_vector = reg_wdata[qin_pkg::VEC_W-1:0];
            qin_pkg::OFF_QUEUE_VECTOR:
               next_state.queue_vector[state.queue_select] =
                  reg_wdata[qin_pkg::VEC_W-1:0];
            qin_pkg::OFF_CONTROL:
               next_state.msix_enable = reg_wdata[qin_pkg::CTRL_MSIX_BIT];
            qin_pkg::OFF_IRQ_STATUS:
               next_state.irq_status = state.irq_status &
                  ~reg_wdata[qin_pkg::NUM_EVENTS-1:0];
            qin_pkg::OFF_IRQ_MASK:
               next_state.irq_mask = reg_wdata[qin_pkg::NUM_EVENTS-1:0];
            default: ;
         endcase
      end
      // an event that finds the slot busy waits here instead of being lost
      next_state.queue_pending = state.queue_pending & q_mapped & ~q_taken;
      next_state.config_pending = state.config_pending && cfg_mapped &&
         !cfg_taken;
      if (state.msix_enable) begin
         if (used_event && used_mapped && !q_taken[used_queue]) begin
            next_state.queue_pending[used_queue] = 1'b1;
         end
         if (config_event && cfg_mapped && !cfg_taken) begin
            next_state.config_pending = 1'b1;
         end
      end else begin
         next_state.queue_pending = '0;
         next_state.config_pending = 1'b0;
      end
      // set wins over clear; both causes may share one line interrupt
      if (!state.msix_enable) begin
         if (used_event) begin
            next_state.cause[qin_pkg::CAUSE_USED_BIT] = 1'b1;
         end
         if (config_event) begin
            next_state.cause[qin_pkg::CAUSE_CFG_BIT] = 1'b1;
         end
      end
      next_state.irq_status = next_state.irq_status | ev;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= '0;
         state.queue_vector <= {qin_pkg::NUM_QUEUES{
            qin_pkg::UNMAPPED_VECTOR_CODE}};
         state.config_vector <= qin_pkg::UNMAPPED_VECTOR_CODE;
         state.irq_mask <= qin_pkg::IRQ_MASK_RESET;
         state.cause <= qin_pkg::CAUSE_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign queue_work = state.work;
   // page number shifted up by the 4096-byte page
   assign ring_base = {state.page_frame[state.queue_select],
                       {qin_pkg::PAGE_SHIFT{1'b0}}};
   assign pci_irq = |state.cause && !state.msix_enable;
   assign irq = |(state.irq_status & state.irq_mask);

   property p_cause_used;
      @(posedge clock) disable iff (!rst_n)
      used_event && !state.msix_enable |=>
         state.cause[qin_pkg::CAUSE_USED_BIT] && pci_irq;
   endproperty
   a_cause_used: assert property (p_cause_used)
      else $error("queue cause not set");

   property p_cause_cfg;
      @(posedge clock) disable iff (!rst_n)
      config_event && !state.msix_enable |=>
         state.cause[qin_pkg::CAUSE_CFG_BIT] && pci_irq;
   endproperty
   a_cause_cfg: assert property (p_cause_cfg)
      else $error("config cause not set");

   property p_queue_msg;
      @(posedge clock) disable iff (!rst_n)
      used_event && state.msix_enable && used_mapped && !busy
      |=> msg_valid && msg_vector == $past(used_vec);
   endproperty
   a_queue_msg: assert property (p_queue_msg)
      else $error("queue message missing");

   property p_queue_sup;
      @(posedge clock) disable iff (!rst_n)
      load |-> is_mapped(load_vector) && state.msix_enable;
   endproperty
   a_queue_sup: assert property (p_queue_sup)
      else $error("unmapped vector sent");

   property p_cfg_msg;
      @(posedge clock) disable iff (!rst_n)
      config_event && !used_event && state.msix_enable && cfg_mapped && !busy
      |=> msg_valid && msg_vector == $past(state.config_vector);
   endproperty
   a_cfg_msg: assert property (p_cfg_msg)
      else $error("config message missing");

   property p_read_clear;
      @(posedge clock) disable iff (!rst_n)
      reg_read && reg_addr == qin_pkg::OFF_CAUSE_FLAGS && !used_event &&
      !config_event |=> state.cause == qin_pkg::CAUSE_RESET &&
      reg_rdata[1:0] == $past(state.cause);
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("cause not cleared by read");

   property p_msix_quiet;
      @(posedge clock) disable iff (!rst_n)
      state.msix_enable && state.cause == qin_pkg::CAUSE_RESET |=>
         state.cause == qin_pkg::CAUSE_RESET || !$past(state.msix_enable);
   endproperty
   a_msix_quiet: assert property (p_msix_quiet)
      else $error("cause used under messages");

   property p_line;
      @(posedge clock) disable iff (!rst_n)
      pci_irq |-> state.cause != qin_pkg::CAUSE_RESET;
   endproperty
   a_line: assert property (p_line)
      else $error("line without cause");

   property p_doorbell;
      @(posedge clock) disable iff (!rst_n)
      reg_write && reg_addr == qin_pkg::OFF_DOORBELL_INDEX &&
      reg_wdata[15:0] < 16'(qin_pkg::NUM_QUEUES) |=>
         queue_work[$past(reg_wdata[qin_pkg::QIDX_W-1:0])];
   endproperty
   a_doorbell: assert property (p_doorbell)
      else $error("doorbell lost");

   property p_cfg_pending;
      @(posedge clock) disable iff (!rst_n)
      config_event && state.msix_enable && cfg_mapped && !cfg_taken
      |=> state.config_pending;
   endproperty
   a_cfg_pending: assert property (p_cfg_pending)
      else $error("config message lost");

   property p_pending_off;
      @(posedge clock) disable iff (!rst_n)
      !state.msix_enable |=>
         !state.config_pending && state.queue_pending == '0;
   endproperty
   a_pending_off: assert property (p_pending_off)
      else $error("message waiting without message interrupts");

   property p_sup_flag;
      @(posedge clock) disable iff (!rst_n)
      state.msix_enable && used_event && !used_mapped |=>
         state.irq_status[qin_pkg::EV_SUPPRESSED];
   endproperty
   a_sup_flag: assert property (p_sup_flag)
      else $error("suppressed event not flagged");

   property p_rdata_idle;
      @(posedge clock) disable iff (!rst_n)
      !reg_read |=> reg_rdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read cycle");
endmodule

// *** hdl/qin_pkg.sv ***
package qin_pkg;
   localparam int unsigned NUM_QUEUES = 4;
   localparam int unsigned QIDX_W = 2;
   localparam int unsigned VEC_W = 16;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PFN_W = 32;
   localparam int unsigned RING_ADDR_W = 44;
   localparam int unsigned PAGE_SHIFT = 12;
   localparam logic [RING_ADDR_W-1:0] PAGE_BYTES = 44'h00000001000;
   localparam logic [VEC_W-1:0] UNMAPPED_VECTOR_CODE = 16'hFFFF;
   localparam logic [15:0] QUEUE_SIZE_DEFAULT = 16'h0100;
   localparam int unsigned CAUSE_USED_BIT = 0;
   localparam int unsigned CAUSE_CFG_BIT = 1;
   localparam logic [1:0] CAUSE_RESET = 2'h0;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_QUEUE_SELECT = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_RING_PAGE_FRAME = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_QUEUE_SIZE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_DOORBELL_INDEX = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_CAUSE_FLAGS = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CONFIG_VECTOR = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_QUEUE_VECTOR = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h24;

   localparam int unsigned CTRL_MSIX_BIT = 0;
   localparam int unsigned NUM_EVENTS = 3;
   localparam int unsigned EV_DOORBELL = 0;
   localparam int unsigned EV_MSG_SENT = 1;
   localparam int unsigned EV_SUPPRESSED = 2;
   localparam logic [NUM_EVENTS-1:0] IRQ_MASK_RESET = 3'h0;
endpackage

// *** verification/qin_host_sink.sv ***
`timescale 1ns/10ps
// host-side message sink: takes one message, promptly or after a stall
module qin_host_sink (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic msg_valid,
   input wire logic [qin_pkg::VEC_W-1:0] msg_vector,
   output logic msg_ready,
   output logic [qin_pkg::VEC_W-1:0] last_vec,
   output logic [7:0] n_msgs
);
   logic [1:0] wait_cnt;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         msg_ready <= 1'b0;
         wait_cnt <= 2'h0;
         n_msgs <= 8'h00;
         last_vec <= 16'h0000;
      end else if (msg_valid && msg_ready) begin
         msg_ready <= 1'b0;
         wait_cnt <= 2'h0;
         n_msgs <= n_msgs + 8'h01;
         last_vec <= msg_vector;
      end else if (msg_valid) begin
         wait_cnt <= wait_cnt + 2'h1;
         msg_ready <= !slow || wait_cnt == 2'h3;
      end
   end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [qin_pkg::ADDR_W-1:0] reg_addr = 8'h00;
   logic [qin_pkg::DATA_W-1:0] reg_wdata = 32'h00000000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [qin_pkg::DATA_W-1:0] reg_rdata;
   logic used_event = 1'b0;
   logic [qin_pkg::QIDX_W-1:0] used_queue = 2'h0;
   logic config_event = 1'b0;
   logic [qin_pkg::NUM_QUEUES-1:0] queue_work;
   logic [qin_pkg::NUM_QUEUES-1:0] queue_work_clear = 4'h0;
   logic [qin_pkg::RING_ADDR_W-1:0] ring_base;
   logic pci_irq, msg_valid, msg_ready, irq;
   logic [qin_pkg::VEC_W-1:0] msg_vector, last_vec;
   logic [7:0] n_msgs;
   logic slow = 1'b0;
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;

   qin_notify dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .used_event(used_event),
      .used_queue(used_queue), .config_event(config_event),
      .queue_work(queue_work), .queue_work_clear(queue_work_clear),
      .ring_base(ring_base), .pci_irq(pci_irq), .msg_valid(msg_valid),
      .msg_vector(msg_vector), .msg_ready(msg_ready), .irq(irq));

   qin_host_sink host_u (.clock(clock), .rst_n(rst_n), .slow(slow),
      .msg_valid(msg_valid), .msg_vector(msg_vector),
      .msg_ready(msg_ready), .last_vec(last_vec), .n_msgs(n_msgs));

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic wrap_up();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic check(input string name, input logic [63:0] seen,
                        input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      check("reg_rdata", {32'h0, reg_rdata}, {32'h0, exp});
   endtask

   task automatic ev(input logic u, input logic [1:0] q, input logic c);
      @(posedge clock);
      used_event <= u;
      used_queue <= q;
      config_event <= c;
      @(posedge clock);
      used_event <= 1'b0;
      config_event <= 1'b0;
      repeat (10) @(posedge clock);
      #1;
   endtask

   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rdchk(qin_pkg::OFF_CONFIG_VECTOR, 32'h0000FFFF);
      for (int q = 0; q < 4; q++) begin
         wr(qin_pkg::OFF_QUEUE_SELECT, q);
         rdchk(qin_pkg::OFF_QUEUE_VECTOR, 32'h0000FFFF);
         rdchk(qin_pkg::OFF_QUEUE_SIZE, 32'h00000100);
      end
      rdchk(8'hFC, 32'h00000000);
      wr(qin_pkg::OFF_QUEUE_SELECT, 32'h2);
      wr(qin_pkg::OFF_RING_PAGE_FRAME, 32'hFFFFFFFF);
      wr(qin_pkg::OFF_RING_PAGE_FRAME, 32'h000ABCDE);
      wr(qin_pkg::OFF_QUEUE_SELECT, 32'h2);
      #1;
      check("ring_base", ring_base, 44'h000ABCDE000);
      check("ring_lsb", ring_base[11:0], 12'h000);
      wr(qin_pkg::OFF_IRQ_MASK, 32'h1);
      wr(qin_pkg::OFF_DOORBELL_INDEX, 32'h3);
      wr(qin_pkg::OFF_DOORBELL_INDEX, 32'h4);
      #1;
      check("queue_work", queue_work, 4'h8);
      check("irq", irq, 1'b1);
      @(posedge clock);
      queue_work_clear <= 4'h8;
      @(posedge clock);
      queue_work_clear <= 4'h0;
      wr(qin_pkg::OFF_IRQ_STATUS, 32'h1);
      #1;
      check("queue_work", queue_work, 4'h0);
      check("irq", irq, 1'b0);
      ev(1'b1, 2'h1, 1'b0);
      check("pci_irq", pci_irq, 1'b1);
      ev(1'b0, 2'h0, 1'b1);
      check("pci_irq", pci_irq, 1'b1);
      // host reads both causes from one line interrupt
      rdchk(qin_pkg::OFF_CAUSE_FLAGS, 32'h3);
      rdchk(qin_pkg::OFF_CAUSE_FLAGS, 32'h0);
      check("pci_irq", pci_irq, 1'b0);
      ev(1'b1, 2'h0, 1'b1);
      rdchk(qin_pkg::OFF_CAUSE_FLAGS, 32'h3);
      check("n_msgs", n_msgs, 8'h00);
      wr(qin_pkg::OFF_CONTROL, 32'h1);
      wr(qin_pkg::OFF_IRQ_MASK, 32'h6);
      ev(1'b1, 2'h1, 1'b0);
      check("n_msgs", n_msgs, 8'h00);
      check("irq", irq, 1'b1);
      rdchk(qin_pkg::OFF_IRQ_STATUS, 32'h4);
      wr(qin_pkg::OFF_IRQ_STATUS, 32'h4);
      wr(qin_pkg::OFF_QUEUE_SELECT, 32'h1);
      wr(qin_pkg::OFF_QUEUE_VECTOR, 32'h5);
      wr(qin_pkg::OFF_CONFIG_VECTOR, 32'h7);
      rdchk(qin_pkg::OFF_QUEUE_VECTOR, 32'h5);
      slow <= 1'b1;
      ev(1'b1, 2'h1, 1'b0);
      check("last_vec", last_vec, 16'h0005);
      slow <= 1'b0;
      ev(1'b0, 2'h0, 1'b1);
      check("last_vec", last_vec, 16'h0007);
      check("n_msgs", n_msgs, 8'h02);
      check("irq", irq, 1'b1);
      wr(qin_pkg::OFF_CONFIG_VECTOR, 32'hFFFF);
      ev(1'b0, 2'h0, 1'b1);
      check("n_msgs", n_msgs, 8'h02);
      check("pci_irq", pci_irq, 1'b0);
      rdchk(qin_pkg::OFF_CAUSE_FLAGS, 32'h0);
      // both sources at once: config message follows the queue message
      wr(qin_pkg::OFF_CONFIG_VECTOR, 32'h7);
      ev(1'b1, 2'h1, 1'b1);
      check("n_msgs", n_msgs, 8'h04);
      check("last_vec", last_vec, 16'h0007);
      check("msg_valid", msg_valid, 1'b0);
      // reset in mid-run unmaps vectors written before it
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check("irq", irq, 1'b0);
      check("msg_valid", msg_valid, 1'b0);
      wr(qin_pkg::OFF_QUEUE_SELECT, 32'h1);
      rdchk(qin_pkg::OFF_QUEUE_VECTOR, 32'h0000FFFF);
      rdchk(qin_pkg::OFF_CONFIG_VECTOR, 32'h0000FFFF);
      rdchk(qin_pkg::OFF_CONTROL, 32'h0);
      wrap_up();
   end
endmodule
